/* hdl/adc_control_result_compare.sv */
// register, trigger, result formatting and compare logic of the converter
//
// What this block does
// - active flag sets when a conversion starts, clears on completion or abort
// - trigger select: 0 starts on status_control_one write, 1 on hardware trigger
// - compare enable bit switches automatic compare of each result on or off
// - compare direction: 0 less than, 1 greater than or equal
// - high result holds upper 4 or 2 bits; unused upper bits read zero
// - results load on completion unless compare enabled and false, or results locked
// - on a compare event the stored result is result minus compare value
// - 12/10-bit: high read locks results until low read; completions then lost
// - 8-bit mode has no read interlock between high and low results
// - changing the mode field invalidates both result registers
// - low result holds bits 7:0, or whole 8-bit result
// - high compare supplies upper 4 or 2 bits; ignored in 8-bit mode
// - low compare bits always compared with lower eight result bits
// - low-power bit selects high-speed or reduced-power converter setting
// - divide field divides the chosen input clock by 1, 2, 4 or 8
// - sample-time bit selects short or long sample period
// - mode field: 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved
// - input clock: bus, bus/2, alternate or internal asynchronous source
// - complete flag per completion or true compare; cleared by status_control_one write or low read
// - status_control_one write aborts an active conversion; starts anew unless channel all ones or hardware trigger selected
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module adc_control_result_compare (
    input wire logic mclk, // 200 MHz clock
    input wire logic rstn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic hwTriggerInput, // hardware trigger, rising edge
    input wire logic altClkTick, // alternate clock enable pulse
    input wire logic asyncClkTick, // internal async clock enable pulse
    input wire logic convDone, // converter finished, one-cycle pulse
    input wire logic [11:0] convData, // raw converter result, right aligned
    output logic convStart, // start pulse to converter
    output logic convAbort, // abort pulse to converter
    output logic [4:0] convChannel, // channel to convert
    output logic [1:0] convMode, // resolution to converter
    output logic convLowPower, // reduced-power setting
    output logic convLongSample, // long sample period
    output logic convClkTick // converter clock enable pulse
);
    typedef struct packed {
        logic [4:0] chan;
        logic cont;
        logic conv_complete_flag;
        logic trigSel;
        logic cmpEn;
        logic cmpGe;
        logic active;
        logic [7:0] cvh;
        logic [7:0] cvl;
        logic [7:0] cfg;
        logic [11:0] result;
        logic lock;
        logic hwPrev;
        logic busHalf;
        logic [2:0] divCnt;
        logic clkTick;
        logic start;
        logic abort;
        logic ready;
        logic slvErr;
        logic [31:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [1:0] mode;
    logic [1:0] divSel;
    logic [1:0] iclk;
    logic srcTick;
    logic [2:0] divLast;
    logic [11:0] resMask;
    logic [11:0] raw;
    logic [11:0] cmpVal;
    logic [11:0] diff;
    logic cmpTrue;
    logic lockMode;
    logic xferDone;
    logic xferFirst;
    logic wrDone;
    logic rdDone;
    logic hit;
    logic swStart;
    logic hwStart;
    logic chanOn;
    logic cocoSet;
    logic [7:0] rdByte;

    always_comb begin
        s_d = s_q;
        mode = s_q.cfg[adc_ctl_pkg::CFG_MODE_LSB +: 2];
        divSel = s_q.cfg[adc_ctl_pkg::CFG_DIV_LSB +: 2];
        iclk = s_q.cfg[adc_ctl_pkg::CFG_ICLK_LSB +: 2];
        // source selection and divider
        unique case (iclk)
            adc_ctl_pkg::ICLK_BUS: srcTick = 1'b1;
            adc_ctl_pkg::ICLK_BUS_HALF: srcTick = s_q.busHalf;
            adc_ctl_pkg::ICLK_ALT: srcTick = altClkTick;
            adc_ctl_pkg::ICLK_ASYNC: srcTick = asyncClkTick;
        endcase
        divLast = 3'((4'h1 << divSel) - 4'h1);
        s_d.busHalf = ~s_q.busHalf;
        s_d.clkTick = 1'b0;
        if (srcTick) begin
            if (s_q.divCnt >= divLast) begin
                s_d.divCnt = 3'h0;
                s_d.clkTick = 1'b1;
            end else begin
                s_d.divCnt = s_q.divCnt + 3'h1;
            end
        end
        // result formatting per mode, reserved mode acts as 12-bit
        unique case (mode)
            adc_ctl_pkg::MODE_8: resMask = 12'h0ff;
            adc_ctl_pkg::MODE_10: resMask = 12'h3ff;
            adc_ctl_pkg::MODE_12, adc_ctl_pkg::MODE_RSVD: resMask = 12'hfff;
        endcase
        raw = convData & resMask;
        cmpVal = {s_q.cvh[3:0], s_q.cvl} & resMask;
        diff = (raw - cmpVal) & resMask;
        cmpTrue = s_q.cmpGe ? (raw >= cmpVal) : (raw < cmpVal);
        lockMode = (mode != adc_ctl_pkg::MODE_8);
        // apb: access answered one cycle after it opens
        xferFirst = psel & penable & ~s_q.ready;
        xferDone = psel & penable & s_q.ready;
        hit = 1'b1;
        unique case (paddr)
            adc_ctl_pkg::OFS_STATUS_ONE:
                rdByte = {s_q.conv_complete_flag, 1'b0, s_q.cont, s_q.chan};
            adc_ctl_pkg::OFS_STATUS_TWO:
                rdByte = {s_q.active, s_q.trigSel, s_q.cmpEn, s_q.cmpGe, 4'h0};
            adc_ctl_pkg::OFS_RESULT_HI: rdByte = {4'h0, s_q.result[11:8]};
            adc_ctl_pkg::OFS_RESULT_LO: rdByte = s_q.result[7:0];
            adc_ctl_pkg::OFS_COMPARE_HI: rdByte = s_q.cvh;
            adc_ctl_pkg::OFS_COMPARE_LO: rdByte = s_q.cvl;
            adc_ctl_pkg::OFS_CONFIG: rdByte = s_q.cfg;
            default: begin
                rdByte = 8'h00;
                hit = 1'b0;
            end
        endcase
        s_d.ready = xferFirst;
        if (xferFirst) begin
            s_d.rdata = pwrite ? 32'h0 : {24'h0, rdByte};
            s_d.slvErr = ~hit;
        end else begin
            s_d.rdata = 32'h0;
            s_d.slvErr = 1'b0;
        end
        wrDone = xferDone & pwrite & hit;
        rdDone = xferDone & ~pwrite & hit;
        s_d.start = 1'b0;
        s_d.abort = 1'b0;
        swStart = 1'b0;
        s_d.hwPrev = hwTriggerInput;
        hwStart = hwTriggerInput & ~s_q.hwPrev & s_q.trigSel;
        // conversion completion
        cocoSet = 1'b0;
        if (convDone && s_q.active) begin
            s_d.active = 1'b0;
            if (!(s_q.lock && lockMode) && (!s_q.cmpEn || cmpTrue)) begin
                s_d.result = s_q.cmpEn ? diff : raw;
                s_d.conv_complete_flag = 1'b1;
                cocoSet = 1'b1;
            end
            if (s_q.cont && s_q.chan != adc_ctl_pkg::CHAN_OFF && !s_q.trigSel) begin
                swStart = 1'b1;
            end
        end
        // register reads with side effects
        if (rdDone && paddr == adc_ctl_pkg::OFS_RESULT_HI && lockMode) begin
            s_d.lock = 1'b1;
        end
        if (rdDone && paddr == adc_ctl_pkg::OFS_RESULT_LO) begin
            s_d.lock = 1'b0;
            // a flag set in this same cycle wins over the read clear
            if (!cocoSet) begin
                s_d.conv_complete_flag = 1'b0;
            end
        end
        if (!lockMode) begin
            s_d.lock = 1'b0;
        end
        // register writes
        if (wrDone) begin
            unique case (paddr)
                adc_ctl_pkg::OFS_STATUS_ONE: begin
                    s_d.chan = pwdata[4:0];
                    s_d.cont = pwdata[adc_ctl_pkg::SC1_CONT_BIT];
                    if (!cocoSet) begin
                        s_d.conv_complete_flag = 1'b0;
                    end
                    if (s_q.active && !(convDone)) begin
                        s_d.abort = 1'b1;
                        s_d.active = 1'b0;
                    end
                    if (pwdata[4:0] != adc_ctl_pkg::CHAN_OFF && !s_q.trigSel) begin
                        swStart = 1'b1;
                    end
                end
                adc_ctl_pkg::OFS_STATUS_TWO: begin
                    s_d.trigSel = pwdata[adc_ctl_pkg::SC2_TRIG_BIT];
                    s_d.cmpEn = pwdata[adc_ctl_pkg::SC2_CMPEN_BIT];
                    s_d.cmpGe = pwdata[adc_ctl_pkg::SC2_CMPGE_BIT];
                end
                adc_ctl_pkg::OFS_COMPARE_HI: s_d.cvh = pwdata[7:0];
                adc_ctl_pkg::OFS_COMPARE_LO: s_d.cvl = pwdata[7:0];
                adc_ctl_pkg::OFS_CONFIG: begin
                    s_d.cfg = pwdata[7:0];
                    if (pwdata[adc_ctl_pkg::CFG_MODE_LSB +: 2] != mode) begin
                        s_d.result = adc_ctl_pkg::RST_RESULT;
                        s_d.lock = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // starting a conversion
        if (hwStart && s_q.chan != adc_ctl_pkg::CHAN_OFF) begin
            swStart = 1'b1;
        end
        if (swStart) begin
            s_d.start = 1'b1;
            s_d.active = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{chan: adc_ctl_pkg::RST_CHAN,
                     cvh: adc_ctl_pkg::RST_COMPARE,
                     cvl: adc_ctl_pkg::RST_COMPARE,
                     cfg: adc_ctl_pkg::RST_CONFIG,
                     result: adc_ctl_pkg::RST_RESULT,
                     rdata: 32'h0,
                     divCnt: 3'h0,
                     default: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.slvErr;
    assign convStart = s_q.start;
    assign convAbort = s_q.abort;
    assign convChannel = s_q.chan;
    assign convMode = s_q.cfg[adc_ctl_pkg::CFG_MODE_LSB +: 2];
    assign convLowPower = s_q.cfg[adc_ctl_pkg::CFG_LOWPWR_BIT];
    assign convLongSample = s_q.cfg[adc_ctl_pkg::CFG_LSMP_BIT];
    assign convClkTick = s_q.clkTick;
endmodule : adc_control_result_compare

/* hdl/adc_ctl_pkg.sv */
// constants for the converter control, result and compare block
package adc_ctl_pkg;
    // register byte addresses
    localparam logic [7:0] OFS_STATUS_ONE = 8'h00;
    localparam logic [7:0] OFS_STATUS_TWO = 8'h04;
    localparam logic [7:0] OFS_RESULT_HI = 8'h08;
    localparam logic [7:0] OFS_RESULT_LO = 8'h0c;
    localparam logic [7:0] OFS_COMPARE_HI = 8'h10;
    localparam logic [7:0] OFS_COMPARE_LO = 8'h14;
    localparam logic [7:0] OFS_CONFIG = 8'h18;
    // status_control_one fields
    localparam int SC1_CONV_COMPLETE_FLAG_BIT = 7;
    localparam int SC1_CONT_BIT = 5;
    localparam logic [4:0] CHAN_OFF = 5'h1f;
    // status_control_two fields
    localparam int SC2_ACTIVE_BIT = 7;
    localparam int SC2_TRIG_BIT = 6;
    localparam int SC2_CMPEN_BIT = 5;
    localparam int SC2_CMPGE_BIT = 4;
    // config_reg fields
    localparam int CFG_LOWPWR_BIT = 7;
    localparam int CFG_DIV_LSB = 5;
    localparam int CFG_LSMP_BIT = 4;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_ICLK_LSB = 0;
    // reset values
    localparam logic [4:0] RST_CHAN = 5'h1f;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_COMPARE = 8'h00;
    localparam logic [11:0] RST_RESULT = 12'h000;
    // conversion modes
    localparam logic [1:0] MODE_8 = 2'h0;
    localparam logic [1:0] MODE_12 = 2'h1;
    localparam logic [1:0] MODE_10 = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;
    // input clock sources
    localparam logic [1:0] ICLK_BUS = 2'h0;
    localparam logic [1:0] ICLK_BUS_HALF = 2'h1;
    localparam logic [1:0] ICLK_ALT = 2'h2;
    localparam logic [1:0] ICLK_ASYNC = 2'h3;
endpackage : adc_ctl_pkg

/* sim/adc_control_result_compare_sva.sv */
// assertion checker for the converter control block
`timescale 1ns/1ps
module adc_control_result_compare_sva (
    input wire logic mclk, // clock
    input wire logic rstn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic hwTriggerInput, // hardware trigger
    input wire logic convStart, // start pulse
    input wire logic [4:0] convChannel, // channel
    input wire logic [1:0] convMode, // resolution
    input wire logic convLowPower, // low power
    input wire logic convLongSample // long sample
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic trigSelQ;
    wire wrDone = psel && penable && pready && pwrite;
    wire sc1Wr = wrDone && paddr == adc_ctl_pkg::OFS_STATUS_ONE;
    // shadow of the trigger select bit
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) trigSelQ <= 1'b0;
        else if (wrDone && paddr == adc_ctl_pkg::OFS_STATUS_TWO) trigSelQ <= pwdata[6];
    end
    ready_in_two_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    sw_start_a: assert property (sc1Wr && pwdata[4:0] != 5'h1f && !trigSelQ |-> ##[1:2] convStart)
        else $error("write did not start");
    no_start_a: assert property (sc1Wr && (trigSelQ || pwdata[4:0] == 5'h1f) |=> !convStart [*2])
        else $error("start not expected");
    hw_start_a: assert property ($rose(hwTriggerInput) && trigSelQ && convChannel != 5'h1f |-> ##[1:3] convStart)
        else $error("trigger did not start");
    start_pulse_a: assert property (convStart |=> !convStart)
        else $error("start longer than a cycle");
    chan_follow_a: assert property (sc1Wr |=> convChannel == $past(pwdata[4:0]))
        else $error("channel not updated");
    cfg_follow_a: assert property (wrDone && paddr == adc_ctl_pkg::OFS_CONFIG |=>
        {convLowPower, convLongSample, convMode} ==
        {$past(pwdata[7]), $past(pwdata[4]), $past(pwdata[3:2])})
        else $error("config outputs wrong");
    cover property (sc1Wr ##[1:2] convStart);
    cover property ($rose(hwTriggerInput) && trigSelQ);
    cover property (pslverr);
endmodule : adc_control_result_compare_sva
bind adc_control_result_compare adc_control_result_compare_sva chk (.mclk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hwTriggerInput,
    .convStart, .convChannel, .convMode, .convLowPower, .convLongSample);

/* sim/adc_control_result_compare_test.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_control_result_compare_test;
    logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, hwTriggerInput = 1'b0, altClkTick = 1'b0, asyncClkTick = 1'b0;
    logic convDone = 1'b0, convStart, convAbort, convLowPower, convLongSample, convClkTick;
    logic [11:0] convData = 12'h000;
    logic [4:0] convChannel;
    logic [1:0] convMode;
    int errCount = 0, numChecks = 0, cyc = 0, ticks;
    int per [4] = '{1, 2, 4, 8};
    logic [7:0] hiE [4] = '{8'h00, 8'h0f, 8'h03, 8'h0f};
    logic [11:0] datE [4] = '{12'h0ff, 12'hfff, 12'h3ff, 12'hfff};
    // index: sc1, sc2, result hi, result lo, compare hi, compare lo, config, unmapped
    logic [7:0] ofs [8] = '{adc_ctl_pkg::OFS_STATUS_ONE, adc_ctl_pkg::OFS_STATUS_TWO,
        adc_ctl_pkg::OFS_RESULT_HI, adc_ctl_pkg::OFS_RESULT_LO, adc_ctl_pkg::OFS_COMPARE_HI,
        adc_ctl_pkg::OFS_COMPARE_LO, adc_ctl_pkg::OFS_CONFIG, 8'h1c};
    adc_control_result_compare DUT (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .hwTriggerInput, .altClkTick, .asyncClkTick, .convDone,
        .convData, .convStart, .convAbort, .convChannel, .convMode, .convLowPower,
        .convLongSample, .convClkTick);
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        altClkTick <= cyc % 4 == 0;
        asyncClkTick <= cyc % 8 == 0;
    end
    task automatic endSim();
        if (errCount == 0 && numChecks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : endSim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input int k, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ofs[k];
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(n, 0);
            endSim();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input int k, input logic [7:0] d);
        xfer(1'b1, k, d);
    endtask : wr
    task automatic rdc(input int k, input logic [7:0] e);
        xfer(1'b0, k, 8'h00);
        chk(rdat, {24'h0, e});
        chk(rerr, k == 7);
    endtask : rdc
    task automatic strt();
        int n;
        n = 0;
        while (convStart !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 20) begin
            chk(n, 0);
            endSim();
        end
    endtask : strt
    task automatic fin(input logic [11:0] d);
        convDone <= 1'b1;
        convData <= d;
        @(posedge mclk);
        convDone <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : fin
    task automatic go(input logic [11:0] d);
        wr(0, 8'h03);
        strt();
        fin(d);
    endtask : go
    initial begin
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        for (int k = 0; k < 8; k++) rdc(k, k == 0 ? 8'h1f : 8'h00);
        wr(1, 8'h00);
        wr(0, 8'h03);
        strt();
        rdc(1, 8'h80);
        wr(0, 8'h03);
        @(posedge mclk);
        chk(convAbort, 1'b1);
        chk(convStart, 1'b1);
        fin(12'h000);
        rdc(1, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(6, 8'(m << 2));
            rdc(3, 8'h00);
            go(datE[m]);
            rdc(0, 8'h83);
            rdc(2, hiE[m]);
            rdc(3, 8'hff);
            rdc(0, 8'h03);
        end
        wr(6, 8'h04);
        go(12'h456);
        rdc(2, 8'h04);
        go(12'h789);
        rdc(3, 8'h56);
        rdc(0, 8'h03);
        wr(6, 8'h00);
        go(12'h012);
        rdc(2, 8'h00);
        go(12'h034);
        rdc(3, 8'h34);
        wr(6, 8'h04);
        wr(4, 8'h01);
        wr(5, 8'h23);
        wr(1, 8'h20);
        go(12'h201);
        rdc(0, 8'h03);
        rdc(3, 8'h00);
        go(12'h100);
        rdc(2, 8'h0f);
        rdc(3, 8'hdd);
        wr(1, 8'h30);
        go(12'h123);
        rdc(0, 8'h83);
        rdc(3, 8'h00);
        wr(6, 8'h00);
        go(12'h033);
        rdc(3, 8'h10);
        wr(1, 8'h40);
        wr(0, 8'h03);
        rdc(1, 8'h40);
        hwTriggerInput <= 1'b1;
        strt();
        hwTriggerInput <= 1'b0;
        fin(12'h066);
        rdc(3, 8'h66);
        wr(1, 8'h00);
        for (int s = 0; s < 4; s++)
            for (int v = 0; v < 4; v++) begin
                wr(6, 8'(8'h90 | (v << 5) | s));
                rdc(6, 8'(8'h90 | (v << 5) | s));
                repeat (16) @(posedge mclk);
                ticks = 0;
                repeat (64) @(posedge mclk) ticks += convClkTick;
                chk(ticks, 64 / (per[s] << v));
            end
        endSim();
    end
endmodule : adc_control_result_compare_test
